// file: scan_verify_output.sv
// Output side of a bar code reader: message formatting, verifier,
// failure counter and two hold-timed outputs.
// Assumes the decoder gives one code character per cycle, ending with
// i_code_last, and pulses trigger start and end once per cycle.
`timescale 1ns/1ps
module scan_verify_output (
  input  wire logic                             i_clock,       // System clock
  input  wire logic                             i_rst_n,       // Async reset
  input  wire logic                             i_trig_start,  // Trigger cycle begins
  input  wire logic                             i_trig_end,    // Trigger cycle ends
  input  wire logic                             i_scan_valid,  // One valid scan
  input  wire logic                             i_code_valid,  // Code char present
  input  wire logic [7:0]                       i_code_char,   // Code character
  input  wire logic                             i_code_last,   // Last char of code
  input  wire logic [7:0]                       i_sep_char,    // Separator setting
  input  wire scan_verify_pkg::verify_mode_type i_mode,        // Verifier mode
  input  wire logic                             i_ref_we,      // Reference write
  input  wire logic [5:0]                       i_ref_addr,    // Reference index
  input  wire logic [7:0]                       i_ref_data,    // Reference char
  input  wire logic [5:0]                       i_ref_len,     // Reference length
  input  wire logic                             i_rts_cts,     // RTS/CTS selected
  input  wire logic [6:0]                       i_fail_hold,   // Failure hold
  input  wire logic [6:0]                       i_good_hold,   // Good hold
  input  wire logic [7:0]                       i_fail_limit,  // Consecutive limit
  output logic                                  o_tx_valid,    // Message byte valid
  output logic [7:0]                            o_tx_data,     // Message byte
  output logic                                  o_tx_quality,  // Byte is quality
  output logic                                  o_fail_output_line, // Failure out
  output logic                                  o_good_output  // Good/match out
);
  import scan_verify_pkg::*;

  typedef struct packed {
    tx_state_type         tx;
    logic                 tx_valid;
    logic [7:0]           tx_data;
    logic                 tx_quality;
    logic [7:0]           quality;
    logic [7:0]           fail_count;
    logic [24:0]          prescale;
    logic                 tick;
    logic [REF_IDX_W-1:0] idx;
    logic [REF_IDX_W-1:0] ref_len;
    logic                 have_code;
    logic                 mismatch;
    logic                 ref_ok;
    logic                 fail_fire;
    logic                 good_fire;
  } state_type;

  state_type  s_reg;
  state_type  s_next;
  logic [7:0] ref_mem_reg [REF_MAX];
  logic       fail_active;
  logic       good_active;
  logic       code_good;
  logic       first_cap;

  // Clip the reference write index so nothing beyond 50 chars exists
  function automatic logic in_ref(input logic [REF_IDX_W-1:0] a);
    return a < REF_IDX_W'(REF_MAX);
  endfunction

  assign code_good = s_reg.have_code && !s_reg.mismatch;
  // First good code of first-code mode becomes the reference
  assign first_cap = i_mode == VERIFY_FIRST && !s_reg.ref_ok;

  // Reference storage, loaded by download or by the first code read
  always_ff @(posedge i_clock) begin
    if (i_ref_we && i_mode == VERIFY_DOWNLOAD && in_ref(i_ref_addr)) begin
      ref_mem_reg[i_ref_addr] <= i_ref_data;
    end else if (first_cap && i_code_valid && in_ref(s_reg.idx)) begin
      ref_mem_reg[s_reg.idx] <= i_code_char;
    end
  end

  // Main next-state logic
  always_comb begin
    s_next           = s_reg;
    s_next.tx_valid  = 1'b0;
    s_next.fail_fire = 1'b0;
    s_next.good_fire = 1'b0;
    // Prescaler; one tick every 50 ms
    s_next.tick = 1'b0;
    if (s_reg.prescale == 25'(TICK_CYCLES - 1)) begin
      s_next.prescale = '0;
      s_next.tick     = 1'b1;
    end else begin
      s_next.prescale = s_reg.prescale + 25'h1;
    end
    if (i_mode == VERIFY_DOWNLOAD) begin
      s_next.ref_len = i_ref_len > 6'(REF_MAX) ? 6'(REF_MAX) : i_ref_len;
      s_next.ref_ok  = 1'b1;
    end else if (i_mode == VERIFY_OFF) begin
      s_next.ref_ok = 1'b0;
    end
    if (i_trig_start) begin
      s_next.quality   = QUALITY_RESET;
      s_next.have_code = 1'b0;
      s_next.mismatch  = 1'b0;
      s_next.idx       = '0;
    end else if (i_scan_valid && s_reg.quality != 8'hff) begin
      s_next.quality = s_reg.quality + 8'h01;
    end
    // Code stream: pass through and compare against reference
    if (i_code_valid) begin
      s_next.tx_valid   = 1'b1;
      s_next.tx_data    = i_code_char;
      s_next.tx_quality = 1'b0;
      s_next.tx         = TX_CODE;
      s_next.idx        = s_reg.idx + 6'h1;
      if (!first_cap && (!in_ref(s_reg.idx) || s_reg.idx >= s_reg.ref_len
          || ref_mem_reg[s_reg.idx] != i_code_char)) begin
        s_next.mismatch = 1'b1;
      end
      if (i_code_last) begin
        s_next.have_code = 1'b1;
        if (!first_cap && s_next.idx != s_reg.ref_len) begin
          s_next.mismatch = 1'b1;
        end
        if (first_cap) begin
          s_next.ref_len = in_ref(s_reg.idx) ? s_next.idx : 6'(REF_MAX);
          s_next.ref_ok  = 1'b1;
        end
        s_next.tx = TX_SEP;
      end
    end else begin
      unique case (s_reg.tx)
        TX_IDLE: begin
          s_next.tx = TX_IDLE;
        end
        TX_CODE: begin
          s_next.tx = TX_CODE;
        end
        TX_SEP: begin
          if (i_sep_char == SEP_OMIT_CHAR) begin
            s_next.tx = TX_IDLE;
          end else if (i_sep_char == SEP_NONE_CHAR) begin
            s_next.tx = TX_QUAL;
          end else begin
            s_next.tx_valid = 1'b1;
            s_next.tx_data  = i_sep_char;
            s_next.tx       = TX_QUAL;
          end
        end
        TX_QUAL: begin
          s_next.tx_valid   = 1'b1;
          s_next.tx_data    = s_reg.quality;
          s_next.tx_quality = 1'b1;
          s_next.tx         = TX_IDLE;
        end
      endcase
    end
    // End of trigger cycle: judge and fire outputs
    if (i_trig_end) begin
      if (i_mode == VERIFY_OFF ? !s_reg.have_code : !code_good) begin
        if (s_reg.fail_count != 8'hff) begin
          s_next.fail_count = s_reg.fail_count + 8'h01;
        end
        // A zero limit can never fire; any other limit fires once the count is at or above it
        if (i_fail_limit != FAIL_RESET
            && s_next.fail_count >= i_fail_limit) begin
          s_next.fail_fire = 1'b1;
        end
      end else begin
        s_next.fail_count = FAIL_RESET;
        s_next.good_fire  = i_mode != VERIFY_OFF && !i_rts_cts;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Two independent hold timers share the one prescaler tick
  hold_timer u_fail_timer (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_tick   (s_reg.tick),
    .i_fire   (s_reg.fail_fire),
    .i_trig   (i_trig_start),
    .i_hold   (i_fail_hold),
    .o_active (fail_active)
  );
  hold_timer u_good_timer (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_tick   (s_reg.tick),
    .i_fire   (s_reg.good_fire),
    .i_trig   (i_trig_start),
    .i_hold   (i_good_hold),
    .o_active (good_active)
  );

  assign o_tx_valid         = s_reg.tx_valid;
  assign o_tx_data          = s_reg.tx_data;
  assign o_tx_quality       = s_reg.tx_quality;
  assign o_fail_output_line = fail_active;
  assign o_good_output      = good_active;

  property p_omit_quality;
    @(posedge i_clock) disable iff (!i_rst_n)
    (s_reg.tx == TX_SEP && !i_code_valid && i_sep_char == 8'h58) |=> !o_tx_valid;
  endproperty
  a_omit_quality: assert property (p_omit_quality)
    else $error("quality sent with omit setting");

  property p_sep_then_qual;
    @(posedge i_clock) disable iff (!i_rst_n)
    (s_reg.tx == TX_SEP && !i_code_valid && i_sep_char != 8'h58 && i_sep_char != 8'h4e)
      |=> (o_tx_data == $past(i_sep_char) && !o_tx_quality);
  endproperty
  a_sep_then_qual: assert property (p_sep_then_qual)
    else $error("separator not sent");

  property p_no_sep;
    @(posedge i_clock) disable iff (!i_rst_n)
    (s_reg.tx == TX_SEP && !i_code_valid && i_sep_char == 8'h4e) |=> !o_tx_valid;
  endproperty
  a_no_sep: assert property (p_no_sep)
    else $error("separator sent with N setting");

  property p_rts_no_good;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_rts_cts |=> !s_reg.good_fire;
  endproperty
  a_rts_no_good: assert property (p_rts_no_good)
    else $error("good fired under RTS/CTS");

  property p_zero_limit;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_fail_limit == 8'h00) |=> !s_reg.fail_fire;
  endproperty
  a_zero_limit: assert property (p_zero_limit)
    else $error("failure fired with zero limit");

  property p_good_clears;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_trig_end && code_good && i_mode != VERIFY_OFF) |=> s_reg.fail_count == 8'h00;
  endproperty
  a_good_clears: assert property (p_good_clears)
    else $error("failure count not cleared");

  property p_quality_count;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_scan_valid && !i_trig_start && s_reg.quality < 8'hfe)
      |=> s_reg.quality == $past(s_reg.quality) + 8'h01;
  endproperty
  a_quality_count: assert property (p_quality_count)
    else $error("quality count missed a scan");

  // Checked every cycle, so it bites long before the first 50 ms tick
  property p_tick_spacing;
    @(posedge i_clock) disable iff (!i_rst_n)
    (s_reg.prescale != 25'(TICK_CYCLES - 1))
      |=> (!s_reg.tick && s_reg.prescale == $past(s_reg.prescale) + 25'h1);
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("ticks too close");

  c_fail: cover property (@(posedge i_clock) s_reg.fail_fire);
  c_good: cover property (@(posedge i_clock) s_reg.good_fire);
  c_qual: cover property (@(posedge i_clock) o_tx_quality);
endmodule

// file: scan_verify_pkg.sv
// Shared constants for the scan verify output block.
// Assumes ASCII code characters and a 100 MHz system clock.
package scan_verify_pkg;
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          TICK_MS         = 50;
  localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int          REF_MAX         = 50;
  localparam int          REF_IDX_W       = 6;
  localparam logic [7:0]  SEP_NONE_CHAR   = 8'h4e;  // 'N'
  localparam logic [7:0]  SEP_OMIT_CHAR   = 8'h58;  // 'X'
  localparam logic [6:0]  HOLD_OFF        = 7'h00;
  localparam logic [6:0]  HOLD_TO_TRIGGER = 7'h63;  // 99
  localparam logic [7:0]  QUALITY_RESET   = 8'h00;
  localparam logic [7:0]  FAIL_RESET      = 8'h00;

  typedef enum logic [1:0] {
    VERIFY_DOWNLOAD = 2'b00,
    VERIFY_FIRST    = 2'b01,
    VERIFY_OFF      = 2'b10
  } verify_mode_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_CODE = 2'b01,
    TX_SEP  = 2'b11,
    TX_QUAL = 2'b10
  } tx_state_type;
endpackage

// file: hold_timer.sv
// One output hold timer counting 50 ms ticks.
// Assumes a one-cycle tick pulse and a one-cycle trigger start pulse.
`timescale 1ns/1ps
module hold_timer (
  input  wire logic       i_clock,    // System clock
  input  wire logic       i_rst_n,    // Async reset, active low
  input  wire logic       i_tick,     // 50 ms tick pulse
  input  wire logic       i_fire,     // Start the hold
  input  wire logic       i_trig,     // Trigger cycle begins
  input  wire logic [6:0] i_hold,     // Hold length in ticks
  output logic            o_active    // Output held, registered
);
  import scan_verify_pkg::*;

  typedef struct packed {
    logic       active;
    logic [6:0] count;
  } state_type;

  state_type s_reg;
  state_type s_next;

  // Load on fire, count down on tick, latch for the 99 setting
  always_comb begin
    s_next = s_reg;
    if (i_trig && s_reg.count == HOLD_TO_TRIGGER) begin
      s_next.active = 1'b0;
      s_next.count  = HOLD_OFF;
    end
    if (i_fire && i_hold != HOLD_OFF) begin
      s_next.active = 1'b1;
      s_next.count  = i_hold;
    end else if (i_tick && s_reg.active && s_reg.count != HOLD_TO_TRIGGER) begin
      s_next.count = s_reg.count - 7'h01;
      if (s_reg.count == 7'h01) begin
        s_next.active = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_active = s_reg.active;

  property p_hold_zero_idle;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_fire && i_hold == 7'h00 && !s_reg.active) |=> !s_reg.active;
  endproperty
  a_hold_zero_idle: assert property (p_hold_zero_idle)
    else $error("hold of zero started the output");
endmodule

// file: scan_decoder_model.sv
// Behavioural model of the decoder core that feeds the output block.
// Assumes each call starts just after a rising clock edge.
`timescale 1ns/1ps
module scan_decoder_model (
  input  wire logic       i_clock,       // System clock
  output logic            o_trig_start,  // Trigger cycle begins
  output logic            o_trig_end,    // Trigger cycle ends
  output logic            o_scan_valid,  // One valid scan
  output logic            o_code_valid,  // Code char present
  output logic [7:0]      o_code_char,   // Code character
  output logic            o_code_last    // Last char of code
);
  initial begin
    {o_trig_start, o_trig_end, o_scan_valid, o_code_valid, o_code_last} = '0;
    o_code_char = 8'h00;
  end

  // Move one edge on, then settle just after it
  task automatic step();
    @(posedge i_clock);
    #1;
  endtask

  // One trigger cycle: scans, code chars, two idle cycles, end pulse
  task automatic run(input logic [7:0] base, input int len, input int scans);
    o_trig_start = 1'b1;
    step();
    o_trig_start = 1'b0;
    repeat (scans) begin
      o_scan_valid = 1'b1;
      step();
    end
    o_scan_valid = 1'b0;
    for (int i = 0; i < len; i++) begin
      o_code_valid = 1'b1;
      o_code_char  = 8'(base + i);
      o_code_last  = (i == len - 1);
      step();
    end
    // Idle char bus flips so a stale byte cannot pass as data
    o_code_valid = 1'b0;
    o_code_last  = 1'b0;
    o_code_char  = ~o_code_char;
    repeat (2) step();
    o_trig_end = 1'b1;
    step();
    o_trig_end = 1'b0;
  endtask
endmodule

// file: scan_verify_output_tb.sv
// Self-checking bench for the scan verify output block.
// Assumes hold 99 for most cases: real tick lengths are too long to simulate.
`timescale 1ns/1ps
module scan_verify_output_tb;
  import scan_verify_pkg::*;
  typedef struct {
    verify_mode_type m;
    logic [7:0]      sep;
    logic [7:0]      base;
    int              len;
    int              scans;
    logic            rts;
    logic            f;
    logic            g;
  } row_type;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_ref_we = 1'b0, i_rts_cts = 1'b0;
  logic trig_start, trig_end, scan_valid, code_valid, code_last;
  logic [7:0] code_char, i_sep_char = 8'h2a, i_ref_data = 8'h00, i_fail_limit = 8'h01;
  logic [5:0] i_ref_addr = 6'h00, i_ref_len = 6'h04;
  logic [6:0] i_fail_hold = 7'h63, i_good_hold = 7'h63;
  verify_mode_type i_mode = VERIFY_DOWNLOAD;
  logic o_tx_valid, o_tx_quality, o_fail_output_line, o_good_output;
  logic [7:0] o_tx_data;
  logic [7:0] txq[$];
  logic       qf[$];
  int fail_count = 0, num_checks = 0;
  row_type rows[10] = '{
    '{VERIFY_DOWNLOAD, 8'h2a, 8'h41, 4, 3, 1'b0, 1'b0, 1'b1},
    '{VERIFY_DOWNLOAD, 8'h4e, 8'h42, 4, 1, 1'b0, 1'b1, 1'b0},
    '{VERIFY_DOWNLOAD, 8'h58, 8'h41, 0, 0, 1'b0, 1'b1, 1'b0},
    '{VERIFY_DOWNLOAD, 8'h58, 8'h41, 4, 2, 1'b1, 1'b0, 1'b0},
    '{VERIFY_DOWNLOAD, 8'h2d, 8'h41, 3, 1, 1'b0, 1'b1, 1'b0},
    '{VERIFY_OFF,      8'h2a, 8'h42, 4, 1, 1'b0, 1'b0, 1'b0},
    '{VERIFY_OFF,      8'h2a, 8'h41, 0, 0, 1'b0, 1'b1, 1'b0},
    '{VERIFY_FIRST,    8'h2a, 8'h50, 4, 1, 1'b0, 1'b0, 1'b1},
    '{VERIFY_FIRST,    8'h2a, 8'h41, 4, 1, 1'b0, 1'b1, 1'b0},
    '{VERIFY_FIRST,    8'h2a, 8'h50, 4, 5, 1'b0, 1'b0, 1'b1}};

  always #5 i_clock = ~i_clock;

  scan_decoder_model dec (.i_clock(i_clock), .o_trig_start(trig_start),
    .o_trig_end(trig_end), .o_scan_valid(scan_valid), .o_code_valid(code_valid),
    .o_code_char(code_char), .o_code_last(code_last));

  scan_verify_output dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_trig_start(trig_start),
    .i_trig_end(trig_end), .i_scan_valid(scan_valid), .i_code_valid(code_valid),
    .i_code_char(code_char), .i_code_last(code_last), .i_sep_char(i_sep_char),
    .i_mode(i_mode), .i_ref_we(i_ref_we), .i_ref_addr(i_ref_addr), .i_ref_data(i_ref_data),
    .i_ref_len(i_ref_len), .i_rts_cts(i_rts_cts), .i_fail_hold(i_fail_hold),
    .i_good_hold(i_good_hold), .i_fail_limit(i_fail_limit), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .o_tx_quality(o_tx_quality),
    .o_fail_output_line(o_fail_output_line), .o_good_output(o_good_output));

  // Collect message bytes; each stands for one cycle only
  always @(posedge i_clock) begin
    if (o_tx_valid === 1'b1) begin
      txq.push_back(o_tx_data);
      qf.push_back(o_tx_quality);
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Sequential reference writes; the caller sets the length separately
  task automatic write_ref(input logic [7:0] base, input int len);
    for (int i = 0; i < len; i++) begin
      i_ref_we   = 1'b1;
      i_ref_addr = 6'(i);
      i_ref_data = 8'(base + i);
      @(posedge i_clock);
      #1;
    end
    i_ref_we = 1'b0;
  endtask

  // One trigger cycle, then the verdict outputs and the message bytes
  task automatic cyc(input verify_mode_type m, input logic [7:0] sep, input logic [7:0] base,
                     input int len, input int scans, input logic rts, input logic ef,
                     input logic eg);
    int n;
    n = len + ((sep == SEP_OMIT_CHAR) ? 0 : ((sep == SEP_NONE_CHAR) ? 1 : 2));
    i_mode     = m;
    i_sep_char = sep;
    i_rts_cts  = rts;
    txq.delete();
    qf.delete();
    dec.run(base, len, scans);
    repeat (4) @(posedge i_clock);
    #1;
    check(32'(o_fail_output_line), 32'(ef));
    check(32'(o_good_output), 32'(eg));
    // A no-read sends no code bytes to compare
    if (len > 0) begin
      check(32'(txq.size()), 32'(n));
      if (txq.size() == n) begin
        for (int i = 0; i < len; i++) check(32'(txq[i]), 32'(8'(base + i)));
        if (n == len + 2) check(32'(txq[len]), 32'(sep));
        if (n > len) check(32'(txq[n-1]), 32'(scans));
        if (n > len) check(32'(qf[n-1]), 32'h1);
      end
    end
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge i_clock);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge i_clock);
    #1;
    check(32'({o_tx_valid, o_fail_output_line, o_good_output}), 32'h0);
    i_rst_n = 1'b1;
    write_ref(8'h41, 4);
    foreach (rows[k]) cyc(rows[k].m, rows[k].sep, rows[k].base, rows[k].len,
                          rows[k].scans, rows[k].rts, rows[k].f, rows[k].g);
    // First-code capture shares the reference storage, so reload it
    i_mode = VERIFY_DOWNLOAD;
    write_ref(8'h41, 4);
    // Three failures in a row needed; a good read restarts the count
    i_fail_limit = 8'h03;
    repeat (2) cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h42, 4, 1, 1'b0, 1'b0, 1'b0);
    cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h42, 4, 1, 1'b0, 1'b1, 1'b0);
    cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h41, 4, 1, 1'b0, 1'b0, 1'b1);
    cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h42, 4, 1, 1'b0, 1'b0, 1'b0);
    // Limit zero never asserts the failure output
    i_fail_limit = 8'h00;
    repeat (3) cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h42, 4, 1, 1'b0, 1'b0, 1'b0);
    // Hold zero switches each output off
    i_fail_limit = 8'h01;
    i_fail_hold  = 7'h00;
    i_good_hold  = 7'h00;
    cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h42, 4, 1, 1'b0, 1'b0, 1'b0);
    cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h41, 4, 1, 1'b0, 1'b0, 1'b0);
    // Hold 99 lasts past any short wait and ends at the next trigger
    i_fail_hold = 7'h63;
    i_good_hold = 7'h63;
    cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h42, 4, 1, 1'b0, 1'b1, 1'b0);
    repeat (300) @(posedge i_clock);
    #1;
    check(32'(o_fail_output_line), 32'h1);
    cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h41, 4, 1, 1'b0, 1'b0, 1'b1);
    // Full fifty-character reference; writes outside download mode are ignored
    write_ref(8'h30, 50);
    i_ref_len = 6'd50;
    cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h30, 50, 2, 1'b0, 1'b0, 1'b1);
    i_mode = VERIFY_OFF;
    write_ref(8'h7a, 1);
    cyc(VERIFY_DOWNLOAD, 8'h2a, 8'h30, 50, 2, 1'b0, 1'b0, 1'b1);
    finish_test();
  end
endmodule
